// *** src/pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input  wire logic mclk,
  input  wire logic rst_sync_n,
  pin_sync_if.sync  pins
);
  // Three stages; a change counts once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < reset_mode_pkg::PIN_W; i++) begin : g_bit
      logic [reset_mode_pkg::SYNC_STAGES-1:0] sh_q;
      logic                                   stable_q;
      always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          sh_q <= '0;
        end else begin
          sh_q <= {sh_q[1:0], pins.raw[i]};
        end
      end
      // Glitch filter looks only at stages two and three
      always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          stable_q <= reset_mode_pkg::PIN_RST[i];
        end else if (sh_q[1] == sh_q[2]) begin
          stable_q <= sh_q[2];
        end
      end
      assign pins.stable[i] = stable_q;
    end
  endgenerate
endmodule
`default_nettype wire

// *** src/pin_sync_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
  logic [5:0] raw;
  logic [5:0] stable;
  modport sync (input raw, output stable);
  modport user (output raw, input stable);
endinterface
`default_nettype wire

// *** src/reset_mode_pkg.sv ***
`default_nettype none
package reset_mode_pkg;
  // Pin synchroniser depth and width of the strap pins
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned MODE_W      = 4;
  localparam int unsigned PIN_W       = 6;
  // Bit positions of the synchronised pins
  localparam int unsigned PIN_PERST   = 0;
  localparam int unsigned PIN_HOLD    = 1;
  localparam int unsigned PIN_MODE_LO = 2;
  // Switch mode codes
  localparam logic [3:0] MODE_SP_PLAIN   = 4'h0;
  localparam logic [3:0] MODE_SP_EE      = 4'h1;
  localparam logic [3:0] MODE_SP_JUMP0   = 4'h2;
  localparam logic [3:0] MODE_SP_JUMP1   = 4'h3;
  localparam logic [3:0] MODE_RSV_LO     = 4'h4;
  localparam logic [3:0] MODE_RSV_HI     = 4'h7;
  localparam logic [3:0] MODE_SP_LAT     = 4'h8;
  localparam logic [3:0] MODE_SP_LAT_EE  = 4'h9;
  localparam logic [3:0] MODE_MP_UA      = 4'hA;
  localparam logic [3:0] MODE_MP_UA_I2C  = 4'hB;
  localparam logic [3:0] MODE_MP_UA_EE   = 4'hC;
  localparam logic [3:0] MODE_MP_UA_BOTH = 4'hD;
  localparam logic [3:0] MODE_MP_DIS     = 4'hE;
  localparam logic [3:0] MODE_MP_DIS_EE  = 4'hF;
  // Values after reset
  localparam logic [3:0] MODE_RST        = 4'h0;
  localparam logic [5:0] PIN_RST         = 6'h00;
  typedef enum logic [1:0] {
    ST_RESET,
    ST_QUASI,
    ST_RUN
  } seq_state_t;
endpackage
`default_nettype wire

// *** src/switch_reset_mode_control.sv ***
// How it works
// - Fundamental reset low resets sequence, outputs and mode decode; pin synchronisers keep running.
// - Hold at reset gives quasi-reset, SMBus alive.
// - Quasi-reset allows register access, no operation.
// - Only clearing halt bit, fundamental reset low, or rst_n low, leaves quasi-reset.
// - Codes 0-3 single partition variants.
// - Codes 8-9 reduced latency single partition.
// - Codes A-D multi-partition, unattached ports.
// - Codes E-F multi-partition, disabled ports.
`timescale 1ns/1ps
`default_nettype none
module switch_reset_mode_control (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       fundamental_reset_n,
  input  wire logic       reset_hold_request,
  input  wire logic [3:0] switch_mode_select,
  input  wire logic       halt_bit_clear,
  output logic            core_reset_n,
  output logic            smbus_active,
  output logic            normal_run,
  output logic            init_start,
  output logic            switch_control_reg_halt,
  output logic [3:0]      mode_code,
  output logic            single_partition,
  output logic            multi_partition,
  output logic            reduced_latency,
  output logic            eeprom_init,
  output logic            eeprom_jump0,
  output logic            eeprom_jump1,
  output logic            i2c_reset,
  output logic            ports_unattached,
  output logic            ports_disabled,
  output logic            mode_reserved
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]                  rst_sh_q;
  logic                        rst_sync_n;
  reset_mode_pkg::seq_state_t  state_q;
  logic                        perst_ok;
  logic                        hold_req;
  logic [3:0]                  mode_pin;
  logic                        release_ev;
  pin_sync_if                  pins ();

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sh_q <= 2'h0;
    end else begin
      rst_sh_q <= {rst_sh_q[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sh_q[1];

  assign pins.raw = {switch_mode_select, reset_hold_request,
                     fundamental_reset_n};

  pin_sync u_sync (
    .mclk       (mclk),
    .rst_sync_n (rst_sync_n),
    .pins       (pins.sync)
  );

  assign perst_ok = pins.stable[reset_mode_pkg::PIN_PERST];
  assign hold_req = pins.stable[reset_mode_pkg::PIN_HOLD];
  // Mode pins assumed static after release, so a plain slice is safe
  // board holds pins
  assign mode_pin = pins.stable[reset_mode_pkg::PIN_MODE_LO +: 4];
  assign release_ev = (state_q == reset_mode_pkg::ST_RESET) && perst_ok;

  ////////////////////////////////////////////////////////////////////////////
  // reset returns sequence
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_q <= reset_mode_pkg::ST_RESET;
    end else if (!perst_ok) begin
      state_q <= reset_mode_pkg::ST_RESET;
    end else begin
      case (state_q)
        reset_mode_pkg::ST_RESET: begin
          state_q <= hold_req ? reset_mode_pkg::ST_QUASI
                              : reset_mode_pkg::ST_RUN;
        end
        reset_mode_pkg::ST_QUASI: begin
          if (halt_bit_clear) begin
            state_q <= reset_mode_pkg::ST_RUN;
          end
        end
        reset_mode_pkg::ST_RUN: begin
          state_q <= reset_mode_pkg::ST_RUN;
        end
        default: begin
          state_q <= reset_mode_pkg::ST_RESET;
        end
      endcase
    end
  end

  // Outputs registered from the next state so they line up with state_q
  // no run while halted
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core_reset_n            <= 1'b0;
      smbus_active            <= 1'b0;
      normal_run              <= 1'b0;
      init_start              <= 1'b0;
      switch_control_reg_halt <= 1'b0;
    end else if (!perst_ok) begin
      core_reset_n            <= 1'b0;
      smbus_active            <= 1'b0;
      normal_run              <= 1'b0;
      init_start              <= 1'b0;
      switch_control_reg_halt <= 1'b0;
    end else begin
      core_reset_n <= 1'b1;
      smbus_active <= 1'b1;
      init_start   <= (release_ev && !hold_req) ||
                      (state_q == reset_mode_pkg::ST_QUASI && halt_bit_clear);
      if (release_ev) begin
        normal_run              <= !hold_req;
        switch_control_reg_halt <= hold_req;
      end else if (state_q == reset_mode_pkg::ST_QUASI && halt_bit_clear) begin
        normal_run              <= 1'b1;
        switch_control_reg_halt <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fundamental reset clears decode
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      mode_code        <= reset_mode_pkg::MODE_RST;
      single_partition <= 1'b0;
      multi_partition  <= 1'b0;
      reduced_latency  <= 1'b0;
      eeprom_init      <= 1'b0;
      eeprom_jump0     <= 1'b0;
      eeprom_jump1     <= 1'b0;
      i2c_reset        <= 1'b0;
      ports_unattached <= 1'b0;
      ports_disabled   <= 1'b0;
      mode_reserved    <= 1'b0;
    end else if (!perst_ok) begin
      mode_code        <= reset_mode_pkg::MODE_RST;
      single_partition <= 1'b0;
      multi_partition  <= 1'b0;
      reduced_latency  <= 1'b0;
      eeprom_init      <= 1'b0;
      eeprom_jump0     <= 1'b0;
      eeprom_jump1     <= 1'b0;
      i2c_reset        <= 1'b0;
      ports_unattached <= 1'b0;
      ports_disabled   <= 1'b0;
      mode_reserved    <= 1'b0;
    end else if (release_ev) begin
      mode_code        <= mode_pin;
      single_partition <= 1'b0;
      multi_partition  <= 1'b0;
      reduced_latency  <= 1'b0;
      eeprom_init      <= 1'b0;
      eeprom_jump0     <= 1'b0;
      eeprom_jump1     <= 1'b0;
      i2c_reset        <= 1'b0;
      ports_unattached <= 1'b0;
      ports_disabled   <= 1'b0;
      mode_reserved    <= 1'b0;
      case (mode_pin)
        reset_mode_pkg::MODE_SP_PLAIN: single_partition <= 1'b1;
        reset_mode_pkg::MODE_SP_EE: begin
          single_partition <= 1'b1;
          eeprom_init      <= 1'b1;
        end
        reset_mode_pkg::MODE_SP_JUMP0: begin
          single_partition <= 1'b1;
          eeprom_jump0     <= 1'b1;
        end
        reset_mode_pkg::MODE_SP_JUMP1: begin
          single_partition <= 1'b1;
          eeprom_jump1     <= 1'b1;
        end
        reset_mode_pkg::MODE_SP_LAT: begin
          single_partition <= 1'b1;
          reduced_latency  <= 1'b1;
        end
        reset_mode_pkg::MODE_SP_LAT_EE: begin
          single_partition <= 1'b1;
          reduced_latency  <= 1'b1;
          eeprom_init      <= 1'b1;
        end
        reset_mode_pkg::MODE_MP_UA: begin
          multi_partition  <= 1'b1;
          ports_unattached <= 1'b1;
        end
        reset_mode_pkg::MODE_MP_UA_I2C: begin
          multi_partition  <= 1'b1;
          ports_unattached <= 1'b1;
          i2c_reset        <= 1'b1;
        end
        reset_mode_pkg::MODE_MP_UA_EE: begin
          multi_partition  <= 1'b1;
          ports_unattached <= 1'b1;
          eeprom_init      <= 1'b1;
        end
        reset_mode_pkg::MODE_MP_UA_BOTH: begin
          multi_partition  <= 1'b1;
          ports_unattached <= 1'b1;
          i2c_reset        <= 1'b1;
          eeprom_init      <= 1'b1;
        end
        reset_mode_pkg::MODE_MP_DIS: begin
          multi_partition <= 1'b1;
          ports_disabled  <= 1'b1;
        end
        reset_mode_pkg::MODE_MP_DIS_EE: begin
          multi_partition <= 1'b1;
          ports_disabled  <= 1'b1;
          eeprom_init     <= 1'b1;
        end
        default: mode_reserved <= 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_n);

  sequence s_release_hold;
    release_ev && hold_req;
  endsequence
  sequence s_release_go;
    release_ev && !hold_req;
  endsequence

  a_reset_clears_all: assert property (
    !perst_ok |=> !core_reset_n && !normal_run && !smbus_active)
    else $error("fundamental reset did not clear outputs");
  a_reset_clears_mode: assert property (
    !perst_ok |=> mode_code == reset_mode_pkg::MODE_RST
      && !single_partition && !multi_partition && !mode_reserved)
    else $error("fundamental reset did not clear mode decode");
  a_hold_enters_quasi: assert property (
    s_release_hold |=> smbus_active && !normal_run
      && state_q == reset_mode_pkg::ST_QUASI)
    else $error("hold did not enter quasi-reset");
  a_quasi_no_run: assert property (
    state_q == reset_mode_pkg::ST_QUASI |-> !normal_run && smbus_active)
    else $error("run while in quasi-reset");
  a_quasi_stays_held: assert property (
    state_q == reset_mode_pkg::ST_QUASI && !halt_bit_clear && perst_ok
      |=> state_q == reset_mode_pkg::ST_QUASI)
    else $error("quasi-reset left without clear");
  a_clear_starts_run: assert property (
    state_q == reset_mode_pkg::ST_QUASI && halt_bit_clear && perst_ok
      |=> normal_run && init_start && !switch_control_reg_halt)
    else $error("clear did not release quasi-reset");
  a_direct_init_start: assert property (
    s_release_go |=> normal_run && init_start && mode_code == $past(mode_pin))
    else $error("no direct start after release");
  a_halt_bit_shown: assert property (
    state_q == reset_mode_pkg::ST_QUASI |-> switch_control_reg_halt)
    else $error("halt bit not set in quasi-reset");
  a_single_codes: assert property (
    release_ev && mode_pin <= reset_mode_pkg::MODE_SP_JUMP1
      |=> single_partition && !reduced_latency && !multi_partition)
    else $error("codes 0-3 not single partition");
  a_latency_codes: assert property (
    release_ev && mode_pin[3:1] == 3'h4
      |=> single_partition && reduced_latency && eeprom_init == mode_code[0])
    else $error("codes 8-9 wrong decode");
  a_unattached_codes: assert property (
    release_ev && mode_pin >= reset_mode_pkg::MODE_MP_UA
      && mode_pin <= reset_mode_pkg::MODE_MP_UA_BOTH
      |=> multi_partition && ports_unattached && !ports_disabled)
    else $error("codes A-D wrong decode");
  a_disabled_codes: assert property (
    release_ev && mode_pin[3:1] == 3'h7
      |=> multi_partition && ports_disabled && eeprom_init == mode_code[0])
    else $error("codes E-F wrong decode");
endmodule
`default_nettype wire

// *** tb/board_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module board_model (
  input  wire logic  mclk,
  output logic       fundamental_reset_n,
  output logic       reset_hold_request,
  output logic [3:0] switch_mode_select,
  output logic       halt_bit_clear
);
  initial begin
    fundamental_reset_n = 1'b0;
    reset_hold_request  = 1'b0;
    switch_mode_select  = 4'h0;
    halt_bit_clear      = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // straps change only in reset
  // Reserved codes are never offered; callers pass legal codes only
  task automatic boot(input logic [3:0] m, input logic h);
    @(posedge mclk);
    fundamental_reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    switch_mode_select  <= m;
    reset_hold_request  <= h;
    repeat (5) @(posedge mclk);
    fundamental_reset_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // master clears halt bit
  task automatic clear_halt();
    @(posedge mclk);
    halt_bit_clear <= 1'b1;
    @(posedge mclk);
    halt_bit_clear <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/switch_reset_mode_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module switch_reset_mode_control_tb;
  logic       mclk;
  logic       rst_n;
  logic       fundamental_reset_n;
  logic       reset_hold_request;
  logic [3:0] switch_mode_select;
  logic       halt_bit_clear;
  logic       core_reset_n, smbus_active, normal_run, init_start;
  logic       switch_control_reg_halt;
  logic [3:0] mode_code;
  logic       single_partition, multi_partition, reduced_latency;
  logic       eeprom_init, eeprom_jump0, eeprom_jump1, i2c_reset;
  logic       ports_unattached, ports_disabled, mode_reserved;
  logic [9:0] flags;
  int         n_mismatch = 0;
  int         tests_run  = 0;
  int         cycles     = 0;

  assign flags = {single_partition, multi_partition, reduced_latency,
                  eeprom_init, eeprom_jump0, eeprom_jump1, i2c_reset,
                  ports_unattached, ports_disabled, mode_reserved};

  switch_reset_mode_control DUT (
    .mclk, .rst_n, .fundamental_reset_n, .reset_hold_request,
    .switch_mode_select, .halt_bit_clear, .core_reset_n, .smbus_active,
    .normal_run, .init_start, .switch_control_reg_halt, .mode_code,
    .single_partition, .multi_partition, .reduced_latency, .eeprom_init,
    .eeprom_jump0, .eeprom_jump1, .i2c_reset, .ports_unattached,
    .ports_disabled, .mode_reserved
  );
  board_model board (
    .mclk, .fundamental_reset_n, .reset_hold_request,
    .switch_mode_select, .halt_bit_clear
  );

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // expected decode per code
  function automatic logic [9:0] exp_flags(input logic [3:0] m);
    logic [9:0] f;
    f[9] = (m < 4'h4) || (m inside {4'h8, 4'h9});
    f[8] = (m >= 4'hA);
    f[7] = (m inside {4'h8, 4'h9});
    f[6] = (m inside {4'h1, 4'h9, 4'hC, 4'hD, 4'hF});
    f[5] = (m == 4'h2);
    f[4] = (m == 4'h3);
    f[3] = (m inside {4'hB, 4'hD});
    f[2] = (m inside {[4'hA:4'hD]});
    f[1] = (m >= 4'hE);
    f[0] = (m inside {[4'h4:4'h7]});
    return f;
  endfunction

  task automatic wait_core(input logic v);
    for (int i = 0; i < 30 && core_reset_n !== v; i++) @(negedge mclk);
    `CHK(core_reset_n, v)
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Every legal code, no halt: capture and start
  task automatic t_modes();
    for (int k = 0; k < 16; k++) begin
      if (k < 4 || k > 7) begin
        board.boot(4'(k), 1'b0);
        wait_core(1'b1);
        `CHK(flags, exp_flags(4'(k)))
        `CHK(mode_code, 4'(k))
        `CHK(normal_run, 1'b1)
        `CHK(init_start, 1'b1)
        @(negedge mclk);
        `CHK(init_start, 1'b0)
      end
    end
  endtask
  // Halted boot, then release by the master
  task automatic t_halt();
    board.boot(4'hE, 1'b1);
    wait_core(1'b1);
    `CHK(smbus_active, 1'b1)
    `CHK(switch_control_reg_halt, 1'b1)
    repeat (10) @(negedge mclk);
    `CHK(normal_run, 1'b0)
    `CHK(init_start, 1'b0)
    `CHK(switch_control_reg_halt, 1'b1)
    board.clear_halt();
    @(negedge mclk);
    `CHK({normal_run, init_start}, 2'h3)
    `CHK(switch_control_reg_halt, 1'b0)
    @(negedge mclk);
    `CHK(init_start, 1'b0)
  endtask
  // Stray clear while running changes nothing
  task automatic t_stray_clear();
    board.clear_halt();
    @(negedge mclk);
    `CHK({normal_run, init_start}, 2'h2)
  endtask
  // Fundamental reset in mid-run, then a new capture
  task automatic t_perst_mid();
    fork
      board.boot(4'hD, 1'b0);
      begin
        wait_core(1'b0);
        `CHK({normal_run, smbus_active, switch_control_reg_halt}, 3'h0)
        `CHK({mode_code, flags}, 14'h0000)
      end
    join
    wait_core(1'b1);
    `CHK(flags, exp_flags(4'hD))
  endtask

  task automatic end_of_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard; whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    t_modes();
    t_halt();
    t_stray_clear();
    t_perst_mid();
    end_of_test();
  end
endmodule
`undef CHK
`default_nettype wire
